// *** pcgc_top.v ***
// pcgc_top.v: memory-mapped peripheral clock gate control register
// assumes a simple single-cycle processor register port on sys_clk
// Functional notes
// RQ1 - bit 0 set stops the dma controller clock, clear lets it run.
// RQ2 - bit 1 set stops the external memory interface clock, clear lets it run.
// RQ3 - bit 2 set stops serial port 0 clock, clear lets it run.
// RQ4 - bit 3 set stops serial port 1 clock, clear lets it run.
// RQ5 - bit 4 set stops serial port 2 clock, clear lets it run.
// RQ6 - a gated peripheral stops entirely until its bit clears.
// RQ7 - writes to a gated peripheral's registers are discarded.
// RQ8 - reads from a gated peripheral return undefined data.
// RQ9 - software waits at least 5 cycles after re-enabling before access.
// RQ10 - each gate can be entered and left any time by rewriting its bit.
// RQ11 - software should not gate a peripheral still in use.
// RQ12 - the control register sits at byte address 019C0200h.
// RQ13 - reset clears all gate bits, and bits 31 to 5 read zero and ignore writes.
`timescale 1ns/1ps
`include "pcgc_defs.vh"
module pcgc_top #(
    parameter NUM_PERIPH = `PCGC_NUM_PERIPH,
    parameter WAKE_CYCLES = `PCGC_WAKE_CYCLES
) (
    input wire sys_clk,
    input wire rst_b,
    input wire cpu_sel,
    input wire cpu_wr,
    input wire [31:0] cpu_addr,
    input wire [31:0] cpu_wdata,
    output reg [31:0] cpu_rdata_r,
    output reg cpu_rvalid_r,
    input wire [NUM_PERIPH-1:0] per_wr,
    input wire [NUM_PERIPH-1:0] per_rd,
    input wire [32*NUM_PERIPH-1:0] per_rdata,
    output reg [NUM_PERIPH-1:0] per_clk_en_r,
    output reg [NUM_PERIPH-1:0] per_wr_pass_r,
    output reg [NUM_PERIPH-1:0] per_ready_r,
    output reg [31:0] per_rdata_out_r,
    output reg per_rvalid_r,
    output reg [NUM_PERIPH-1:0] clock_off_out_r
);
    reg rst_meta_r;
    reg rst_b_sync;
    reg [NUM_PERIPH-1:0] ctrl_r;
    reg [31:0] mux_data;
    reg any_rd;
    wire [NUM_PERIPH-1:0] clk_en_w;
    wire [NUM_PERIPH-1:0] wr_pass_w;
    wire [NUM_PERIPH-1:0] ready_w;
    wire ctrl_hit;
    integer i;
    localparam [31:0] CTRL_RESET = `PCGC_CTRL_RESET;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_b_sync <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_b_sync <= rst_meta_r;
        end
    end

    assign ctrl_hit = cpu_sel & (cpu_addr == `PCGC_CTRL_ADDR); // [RQ12]

    // one gating bit per peripheral: dma, ext mem if, serial ports 0..2
    always @(posedge sys_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            ctrl_r <= CTRL_RESET[NUM_PERIPH-1:0]; // [RQ13]
            cpu_rdata_r <= 32'h00000000;
            cpu_rvalid_r <= 1'b0;
        end else begin
            cpu_rvalid_r <= ctrl_hit & ~cpu_wr;
            if (ctrl_hit && cpu_wr) begin
                ctrl_r <= cpu_wdata[NUM_PERIPH-1:0]; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ10]
            end
            if (ctrl_hit && !cpu_wr) begin
                cpu_rdata_r <= {{(32-NUM_PERIPH){1'b0}}, ctrl_r}; // [RQ13]
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PERIPH; g = g + 1) begin : gen_gate
            pcgc_periph_gate #(
                .WAKE_CYCLES(WAKE_CYCLES)
            ) u_gate (
                .sys_clk(sys_clk),
                .rst_b_sync(rst_b_sync),
                .clock_off(ctrl_r[g]),
                .per_wr(per_wr[g]),
                .clk_en_r(clk_en_w[g]),
                .wr_pass_r(wr_pass_w[g]),
                .ready_r(ready_w[g])
            );
        end
    endgenerate

    always @* begin
        mux_data = 32'h00000000;
        any_rd = 1'b0;
        for (i = 0; i < NUM_PERIPH; i = i + 1) begin
            if (per_rd[i]) begin
                any_rd = 1'b1;
                if (ctrl_r[i]) begin
                    mux_data = `PCGC_INVALID_DATA; // [RQ8]
                end else begin
                    mux_data = per_rdata[32*i +: 32];
                end
            end
        end
    end

    always @(posedge sys_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            per_clk_en_r <= {NUM_PERIPH{1'b1}};
            per_wr_pass_r <= {NUM_PERIPH{1'b0}};
            per_ready_r <= {NUM_PERIPH{1'b1}};
            per_rdata_out_r <= 32'h00000000;
            per_rvalid_r <= 1'b0;
            clock_off_out_r <= {NUM_PERIPH{1'b0}};
        end else begin
            per_clk_en_r <= clk_en_w; // [RQ6]
            per_wr_pass_r <= wr_pass_w; // [RQ7]
            per_ready_r <= ready_w; // [RQ9]
            per_rdata_out_r <= mux_data;
            per_rvalid_r <= any_rd;
            clock_off_out_r <= ctrl_r;
        end
    end
endmodule // pcgc_top

// *** pcgc_defs.vh ***
// pcgc_defs.vh: constants for the peripheral clock gate control block
// assumes inclusion by bare name from the design files
`ifndef PCGC_DEFS_VH
`define PCGC_DEFS_VH
`define PCGC_CTRL_ADDR 32'h019C0200
`define PCGC_CTRL_RESET 32'h00000000
`define PCGC_NUM_PERIPH 5
`define PCGC_BIT_DMA 0
`define PCGC_BIT_EXT_MEM 1
`define PCGC_BIT_SP0 2
`define PCGC_BIT_SP1 3
`define PCGC_BIT_SP2 4
`define PCGC_FIELD_MASK 32'h0000001F
`define PCGC_WAKE_CYCLES 5
`define PCGC_INVALID_DATA 32'hDEADBEEF
`endif

// *** pcgc_periph_gate.v ***
// pcgc_periph_gate.v: per-peripheral gate, write suppression and wake hold-off
// assumes synchronous inputs on sys_clk and an already synchronised reset
`timescale 1ns/1ps
`include "pcgc_defs.vh"
module pcgc_periph_gate #(
    parameter WAKE_CYCLES = `PCGC_WAKE_CYCLES
) (
    input wire sys_clk,
    input wire rst_b_sync,
    input wire clock_off,
    input wire per_wr,
    output reg clk_en_r,
    output reg wr_pass_r,
    output reg ready_r
);
    reg [3:0] wake_cnt_r;
    reg [3:0] wake_cnt_nxt;

    always @* begin
        wake_cnt_nxt = wake_cnt_r;
        if (clock_off) begin
            wake_cnt_nxt = WAKE_CYCLES[3:0];
        end else if (wake_cnt_r != 4'h0) begin
            wake_cnt_nxt = wake_cnt_r - 4'h1;
        end
    end

    always @(posedge sys_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            clk_en_r <= 1'b1;
            wr_pass_r <= 1'b0;
            ready_r <= 1'b1;
            wake_cnt_r <= 4'h0;
        end else begin
            clk_en_r <= ~clock_off; // [RQ6] [RQ10]
            wr_pass_r <= per_wr & ~clock_off; // [RQ7]
            wake_cnt_r <= wake_cnt_nxt;
            ready_r <= ~clock_off & (wake_cnt_nxt == 4'h0);
        end
    end
endmodule // pcgc_periph_gate

// *** pcgc_top_asserts.sv ***
// pcgc_top_asserts.sv: port checker for the clock gate control block
// assumes one-hot peripheral reads and binding to pcgc_top
`timescale 1ns/1ps
`include "pcgc_defs.vh"
module pcgc_chk #(parameter NUM_PERIPH = 5) (
    input wire sys_clk,
    input wire rst_b,
    input wire cpu_sel,
    input wire cpu_wr,
    input wire [31:0] cpu_addr,
    input wire [31:0] cpu_wdata,
    input wire [31:0] cpu_rdata_r,
    input wire cpu_rvalid_r,
    input wire [NUM_PERIPH-1:0] per_wr,
    input wire [NUM_PERIPH-1:0] per_rd,
    input wire [NUM_PERIPH-1:0] per_clk_en_r,
    input wire [NUM_PERIPH-1:0] per_wr_pass_r,
    input wire [NUM_PERIPH-1:0] per_ready_r,
    input wire [31:0] per_rdata_out_r,
    input wire [NUM_PERIPH-1:0] clock_off_out_r
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_b);
wire hit = cpu_sel && cpu_addr == `PCGC_CTRL_ADDR;
sequence ctrl_wr; hit && cpu_wr; endsequence
sequence gated_wr; (per_wr & clock_off_out_r) != 0 ##1 $stable(clock_off_out_r); endsequence
ctrl_upd_a: assert property (ctrl_wr |-> ##2
    clock_off_out_r == $past(cpu_wdata[4:0], 2)) else $error("ctrl bits wrong");
clk_gate_a: assert property (ctrl_wr |-> ##3
    per_clk_en_r == ~$past(cpu_wdata[4:0], 3)) else $error("clock enable wrong");
rd_resv_a: assert property (hit && !cpu_wr |=>
    cpu_rvalid_r && cpu_rdata_r[31:5] == 0) else $error("read answer wrong");
rd_cause_a: assert property (cpu_rvalid_r |->
    $past(hit && !cpu_wr)) else $error("read answer without read");
wr_block_a: assert property (gated_wr |=>
    (per_wr_pass_r & $past(clock_off_out_r)) == 0) else $error("gated write passed");
rd_bad_a: assert property ((per_rd & clock_off_out_r) != 0 && $stable(clock_off_out_r) |=>
    per_rdata_out_r == `PCGC_INVALID_DATA) else $error("gated read data wrong");
gate_stop_a: assert property (|clock_off_out_r |=>
    (per_ready_r & $past(clock_off_out_r)) == 0) else $error("gated peripheral ready");
wake_hold_a: assert property ($fell(clock_off_out_r[0]) |->
    !per_ready_r[0] [*5] ##[1:8] per_ready_r[0]) else $error("wake timing wrong");
endmodule // pcgc_chk

// *** test_pcgc_top.sv ***
// test_pcgc_top.sv: self-checking bench for the clock gate control block
// assumes design files and checker compiled before it
`timescale 1ns/1ps
`include "pcgc_defs.vh"
module test_pcgc_top;
reg sys_clk = 0, rst_b = 0, cpu_sel = 0, cpu_wr = 0;
reg [31:0] cpu_addr = 0, cpu_wdata = 0;
reg [4:0] per_wr = 0, per_rd = 0;
reg [159:0] per_rdata = {32'h44, 32'h33, 32'h22, 32'h11, 32'h00};
wire [31:0] cpu_rdata_r, per_rdata_out_r;
wire cpu_rvalid_r, per_rvalid_r;
wire [4:0] per_clk_en_r, per_wr_pass_r, per_ready_r, clock_off_out_r;
integer n_errors = 0, checks = 0, i;
always #25 sys_clk = ~sys_clk;
pcgc_top pcgc_top_i (.*);
task chk(input [95:0] nm, input [31:0] s, input [31:0] e);
    checks = checks + 1;
    if (s !== e) begin
        n_errors = n_errors + 1;
        $display("mismatch %0s exp %h saw %h", nm, e, s);
    end
endtask
task acc(input w, input [31:0] a, input [31:0] d);
    cpu_sel = 1;
    cpu_wr = w;
    cpu_addr = a;
    cpu_wdata = d;
    @(posedge sys_clk);
    #1 cpu_sel = 0;
    @(posedge sys_clk);
    #1;
endtask
task end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task t_regs;
    chk("clk_en", per_clk_en_r, 5'h1F);
    for (i = 0; i < 5; i = i + 1) begin
        acc(1, `PCGC_CTRL_ADDR, 32'hFFFFFFE0 | (1 << i));
        acc(0, `PCGC_CTRL_ADDR, 0);
        chk("ctrl", cpu_rdata_r, 1 << i);
        chk("clk_en", per_clk_en_r, 5'h1F ^ (5'h01 << i));
    end
    acc(1, `PCGC_CTRL_ADDR + 4, 32'h1F);
    acc(0, `PCGC_CTRL_ADDR, 0);
    chk("unmapped", cpu_rdata_r, 32'h10);
    $display("t_regs done");
endtask
task t_gate;
    acc(1, `PCGC_CTRL_ADDR, 32'h3);
    repeat (2) @(posedge sys_clk);
    #1 per_wr = 5'h1F;
    per_rd = 5'h01;
    @(posedge sys_clk);
    #1 per_wr = 0;
    per_rd = 5'h04;
    chk("rd_bad", per_rdata_out_r, `PCGC_INVALID_DATA);
    @(posedge sys_clk);
    #1 per_rd = 0;
    chk("wr_pass", per_wr_pass_r, 5'h1C);
    chk("rd_ok", per_rdata_out_r, 32'h22);
    chk("rvalid", per_rvalid_r, 1);
    chk("clk_off", clock_off_out_r, 5'h03);
    $display("t_gate done");
endtask
task t_wake;
    acc(1, `PCGC_CTRL_ADDR, 0);
    chk("ready", per_ready_r, 5'h1C);
    // software hold-off after re-enabling, well over the minimum
    repeat (10) @(posedge sys_clk);
    #1 chk("ready", per_ready_r, 5'h1F);
    // only the re-enabled dma port is written once it is usable
    per_wr = 5'h01;
    @(posedge sys_clk);
    #1 per_wr = 0;
    @(posedge sys_clk);
    #1 chk("wr_wake", per_wr_pass_r, 5'h01);
    $display("t_wake done");
endtask
initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1;
    repeat (3) @(posedge sys_clk);
    #1 t_regs;
    t_gate;
    t_wake;
    end_sim;
end
initial begin
    #20000;
    n_errors = n_errors + 1;
    end_sim;
end
endmodule // test_pcgc_top
bind pcgc_top pcgc_chk #(.NUM_PERIPH(NUM_PERIPH)) pcgc_chk_i (.*);
